/* File: ahz_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
// Function
// - Request forces motor outputs Hi-Z autonomously
// - Mode 0x0004: rising edge enters, stop anytime
// - Mode 0x0014: rising edge enters, stop if inactive
// - Qualified mode ignores stop while request active
// - Writing 0x01 to stop trigger releases
// - Write enable 0x01 allows mode changes
// - Start trigger enable 0x01 arms activation
module ahz_ctrl (
   input wire logic mclk,
   input wire logic srst,
   input wire logic hiz_req, // Hi-Z request from interconnect
   input wire logic [ahz_pkg::AHZ_PWM_W-1:0] pwm_in, // Timer PWM drive
   input wire logic mode_wr, // Strobe: write hiz_mode_config
   input wire logic [15:0] mode_wdata, // Mode value to write
   input wire logic we_wr, // Strobe: write write-enable register
   input wire logic [7:0] we_wdata,
   input wire logic start_wr, // Strobe: write start trigger enable
   input wire logic [7:0] start_wdata,
   input wire logic stop_wr, // Strobe: write stop trigger register
   input wire logic [7:0] stop_wdata,
   output logic [ahz_pkg::AHZ_PWM_W-1:0] pwm_out, // Pin output level
   output logic [ahz_pkg::AHZ_PWM_W-1:0] pwm_oe, // High while pins driven
   output logic hiz_active, // Hi-Z state status
   output logic [15:0] hiz_mode_config, // Current mode readback
   output logic hiz_write_enable, // Write enable readback
   output logic hiz_start_armed // Start trigger readback
);
   import ahz_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Mode decode, shared by the release check and assertions
   function automatic logic qual_mode(input logic [15:0] m);
      return m[AHZ_QUAL_BIT];
   endfunction : qual_mode

   typedef struct packed {
      ahz_state_t state; // Drive or Hi-Z
      logic [15:0] mode; // Mode configuration
      logic wen; // Configuration write enable
      logic arm; // Start trigger enabled
      logic [AHZ_PWM_W-1:0] pout; // Registered pin level
      logic [AHZ_PWM_W-1:0] poe; // Registered pin enable
   } ahz_ctrl_st_t;

   ahz_ctrl_st_t st_q;
   ahz_ctrl_st_t st_d;
   ahz_edge_if edge_b ();
   logic stop_req; // Software stop request this cycle
   logic stop_ok; // Stop allowed by release mode

   ////////////////////////////////////////////////////////////////////////
   // Request edge detector
   // Edge is taken from the gated request only, so the source select is the
   // interconnect's job; this block sees one request wire and nothing else
   ahz_edge_det i_ahz_edge_det (
      .mclk(mclk),
      .srst(srst),
      .req_in(hiz_req), // Gated by interconnect source enable
      .edge_o(edge_b)
   );

   assign stop_req = stop_wr && (stop_wdata == AHZ_ENABLE_VAL);
   // Qualified mode needs an inactive request; free mode always allows
   // Raw request, not the registered level: a stop is refused while the
   // pin is still high, even if the edge register has not caught up yet
   assign stop_ok = stop_req && !(qual_mode(st_q.mode) && hiz_req);

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_d = st_q;
      // Mode only changes while write enable is set; enable and arm writes always land
      if (we_wr) begin
         st_d.wen = (we_wdata == AHZ_ENABLE_VAL);
      end
      if (mode_wr && st_q.wen) begin
         st_d.mode = mode_wdata;
      end
      if (start_wr) begin
         st_d.arm = (start_wdata == AHZ_ENABLE_VAL);
      end
      case (st_q.state)
         AHZ_DRIVE: begin
            // Armed edge wins; no CPU step involved
            if (edge_b.rise && st_q.arm) begin
               st_d.state = AHZ_HIZ;
            end
         end
         AHZ_HIZ: begin
            // Later edges are ignored; only a permitted stop leaves
            if (stop_ok) begin
               st_d.state = AHZ_DRIVE;
            end
         end
         default: begin
            st_d.state = AHZ_DRIVE;
         end
      endcase
      // Pins follow the next state so outputs stay flop-driven
      st_d.pout = (st_d.state == AHZ_HIZ) ? '0 : pwm_in;
      st_d.poe = (st_d.state == AHZ_HIZ) ? '0 : '1;
   end

   // State register
   always_ff @(posedge mclk) begin
      if (srst) begin
         st_q.state <= AHZ_DRIVE;
         st_q.mode <= AHZ_MODE_RST;
         st_q.wen <= 1'b0;
         st_q.arm <= 1'b0;
         st_q.pout <= '0;
         st_q.poe <= '1;
      end else begin
         st_q <= st_d;
      end
   end

   assign pwm_out = st_q.pout;
   assign pwm_oe = st_q.poe;
   assign hiz_active = (st_q.state == AHZ_HIZ);
   assign hiz_mode_config = st_q.mode;
   assign hiz_write_enable = st_q.wen;
   assign hiz_start_armed = st_q.arm;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_enter;
      @(posedge mclk) disable iff (srst)
      (hiz_req && !$past(hiz_req) && hiz_start_armed && !hiz_active) |=> ##1 hiz_active;
   endproperty
   a_enter: assert property (p_enter) else $error("armed rising edge did not enter Hi-Z");

   property p_oe_off;
      @(posedge mclk) disable iff (srst)
      hiz_active |-> (pwm_oe == '0);
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("pins driven in Hi-Z");

   property p_free_rel;
      @(posedge mclk) disable iff (srst)
      (hiz_active && !qual_mode(hiz_mode_config) && stop_wr && stop_wdata == 8'h01)
         |=> !hiz_active;
   endproperty
   a_free_rel: assert property (p_free_rel) else $error("free release failed");

   property p_qual_rel;
      @(posedge mclk) disable iff (srst)
      (hiz_active && qual_mode(hiz_mode_config) && !hiz_req && stop_wr && stop_wdata == 8'h01)
         |=> !hiz_active;
   endproperty
   a_qual_rel: assert property (p_qual_rel) else $error("qualified release failed");

   property p_qual_hold;
      @(posedge mclk) disable iff (srst)
      (hiz_active && qual_mode(hiz_mode_config) && hiz_req) |=> hiz_active;
   endproperty
   a_qual_hold: assert property (p_qual_hold) else $error("stop taken while active");

   property p_no_stop;
      @(posedge mclk) disable iff (srst)
      (hiz_active && !(stop_wr && stop_wdata == 8'h01)) |=> hiz_active;
   endproperty
   a_no_stop: assert property (p_no_stop) else $error("Hi-Z left without stop");

   property p_wen;
      @(posedge mclk) disable iff (srst)
      (!hiz_write_enable && !we_wr) |=> $stable(hiz_mode_config);
   endproperty
   a_wen: assert property (p_wen) else $error("mode changed without write enable");

   property p_unarmed;
      @(posedge mclk) disable iff (srst)
      (!hiz_active && !hiz_start_armed && !start_wr) |=> !hiz_active;
   endproperty
   a_unarmed: assert property (p_unarmed) else $error("entered Hi-Z while unarmed");

   property p_drive;
      @(posedge mclk) disable iff (srst)
      !hiz_active |-> (pwm_oe == '1 && pwm_out == $past(pwm_in));
   endproperty
   a_drive: assert property (p_drive) else $error("PWM not passed in drive");

   // Write strobes land one cycle later, whatever the latch state; mode writes land only while write enable is set
   property p_wen_wr;
      @(posedge mclk) disable iff (srst)
      we_wr |=> (hiz_write_enable == ($past(we_wdata) == 8'h01));
   endproperty
   a_wen_wr: assert property (p_wen_wr) else $error("write enable not updated");

   property p_mode_wr;
      @(posedge mclk) disable iff (srst)
      (mode_wr && hiz_write_enable) |=> (hiz_mode_config == $past(mode_wdata));
   endproperty
   a_mode_wr: assert property (p_mode_wr) else $error("enabled mode write lost");

   property p_arm_wr;
      @(posedge mclk) disable iff (srst)
      start_wr |=> (hiz_start_armed == ($past(start_wdata) == 8'h01));
   endproperty
   a_arm_wr: assert property (p_arm_wr) else $error("start enable not updated");

   // Pins also read low, so nothing stale shows if the enable is ignored
   property p_pout_zero;
      @(posedge mclk) disable iff (srst)
      hiz_active |-> (pwm_out == '0);
   endproperty
   a_pout_zero: assert property (p_pout_zero) else $error("pin level not low in Hi-Z");

   // Edge pulse lasts one cycle, so a held request cannot re-enter
   property p_rise_once;
      @(posedge mclk) disable iff (srst)
      edge_b.rise |=> !edge_b.rise;
   endproperty
   a_rise_once: assert property (p_rise_once) else $error("edge pulse too long");

   // Main scenarios seen by the bench
   c_enter: cover property (@(posedge mclk) disable iff (srst) !hiz_active ##1 hiz_active);
   c_free: cover property (@(posedge mclk) disable iff (srst)
      hiz_active && !qual_mode(hiz_mode_config) ##1 !hiz_active);
   c_qual: cover property (@(posedge mclk) disable iff (srst)
      hiz_active && qual_mode(hiz_mode_config) && hiz_req && stop_wr ##1 hiz_active);
   c_qual_rel: cover property (@(posedge mclk) disable iff (srst)
      hiz_active && qual_mode(hiz_mode_config) && !hiz_req && stop_wr ##1 !hiz_active);
   c_locked: cover property (@(posedge mclk) disable iff (srst)
      mode_wr && !hiz_write_enable);
endmodule : ahz_ctrl
`default_nettype wire

/* File: ahz_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin num_errors++; \
   $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module ahz_ctrl_tb;
   import ahz_pkg::*;
   logic mclk = 1'b0; // 200 MHz clock
   logic srst = 1'b1; // Held for 8 cycles
   logic timer_err = 1'b0; // Timer error into the far model
   logic [7:0] src_en = 8'h00; // Interconnect source select
   logic hiz_req, hiz_active, hiz_write_enable, hiz_start_armed;
   logic [AHZ_PWM_W-1:0] pwm_in, pwm_out, pwm_oe;
   logic [15:0] hiz_mode_config, mode_wdata = 16'h0000;
   logic mode_wr = 1'b0, we_wr = 1'b0, start_wr = 1'b0, stop_wr = 1'b0;
   logic [7:0] wd8 = 8'h00; // Shared byte data for the 8-bit writes
   int num_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   ////////////////////////////////////////////////////////////////////////
   ahz_far_model i_ahz_far_model (.mclk(mclk), .srst(srst), .timer_err(timer_err),
      .hiz_source_enable(src_en), .hiz_req(hiz_req), .pwm_in(pwm_in));
   ahz_ctrl i_ahz_ctrl (.mclk(mclk), .srst(srst), .hiz_req(hiz_req), .pwm_in(pwm_in),
      .mode_wr(mode_wr), .mode_wdata(mode_wdata), .we_wr(we_wr), .we_wdata(wd8),
      .start_wr(start_wr), .start_wdata(wd8), .stop_wr(stop_wr), .stop_wdata(wd8),
      .pwm_out(pwm_out), .pwm_oe(pwm_oe), .hiz_active(hiz_active),
      .hiz_mode_config(hiz_mode_config), .hiz_write_enable(hiz_write_enable),
      .hiz_start_armed(hiz_start_armed));
   ////////////////////////////////////////////////////////////////////////
   // Clock
   initial begin
      forever #2.5 mclk = ~mclk;
   end
   // Hang guard: the run needs a few hundred cycles at most
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         finish_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // One-cycle write strobe: k 0 mode, 1 write enable, 2 start, 3 stop
   task automatic wr(input int k, input logic [15:0] d);
      @(negedge mclk);
      mode_wdata = d;
      wd8 = d[7:0];
      mode_wr = (k == 0);
      we_wr = (k == 1);
      start_wr = (k == 2);
      stop_wr = (k == 3);
      @(negedge mclk);
      {mode_wr, we_wr, start_wr, stop_wr} = 4'h0;
   endtask : wr
   // Timer error level; three cycles cover edge register plus state
   task automatic err(input logic v);
      @(negedge mclk);
      timer_err = v;
      repeat (3) @(negedge mclk);
   endtask : err
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      srst = 1'b0;
      src_en = 8'h08;
      `CHK("hiz_active", 1'b0, hiz_active)
      `CHK("oe", {AHZ_PWM_W{1'b1}}, pwm_oe)
      `CHK("mode", AHZ_MODE_RST, hiz_mode_config)
      $display("test reset done");
      // Mode write refused until write enable is set
      wr(0, AHZ_MODE_FREE_REL);
      `CHK("mode", AHZ_MODE_RST, hiz_mode_config)
      wr(1, 16'h0001);
      `CHK("wen", 1'b1, hiz_write_enable)
      wr(0, AHZ_MODE_FREE_REL);
      `CHK("mode", AHZ_MODE_FREE_REL, hiz_mode_config)
      // Unarmed edge and unselected source do nothing
      err(1'b1);
      `CHK("hiz_active", 1'b0, hiz_active)
      err(1'b0);
      wr(2, 16'h0001);
      `CHK("armed", 1'b1, hiz_start_armed)
      src_en = 8'h00;
      err(1'b1);
      `CHK("hiz_active", 1'b0, hiz_active)
      err(1'b0);
      src_en = 8'h08;
      $display("test config done");
      // Free release: enter, stay latched, odd stop value ignored
      err(1'b1);
      `CHK("hiz_active", 1'b1, hiz_active)
      `CHK("oe", {AHZ_PWM_W{1'b0}}, pwm_oe)
      `CHK("pwm_out", {AHZ_PWM_W{1'b0}}, pwm_out)
      err(1'b0);
      err(1'b1);
      `CHK("hiz_active", 1'b1, hiz_active)
      wr(3, 16'h0002);
      `CHK("hiz_active", 1'b1, hiz_active)
      wr(3, 16'h0001);
      `CHK("hiz_active", 1'b0, hiz_active)
      `CHK("oe", {AHZ_PWM_W{1'b1}}, pwm_oe)
      `CHK("pwm_out", AHZ_PWM_W'(pwm_in - AHZ_PWM_W'(1)), pwm_out)
      err(1'b0);
      $display("test free release done");
      // Qualified release: stop ignored while request high
      wr(0, AHZ_MODE_QUAL_REL);
      `CHK("mode", AHZ_MODE_QUAL_REL, hiz_mode_config)
      err(1'b1);
      `CHK("hiz_active", 1'b1, hiz_active)
      wr(3, 16'h0001);
      `CHK("hiz_active", 1'b1, hiz_active)
      err(1'b0);
      wr(3, 16'h0001);
      `CHK("hiz_active", 1'b0, hiz_active)
      // Write enable cleared locks the mode again
      wr(1, 16'h0000);
      wr(0, AHZ_MODE_FREE_REL);
      `CHK("mode", AHZ_MODE_QUAL_REL, hiz_mode_config)
      $display("test qualified release done");
      // Any value but 0x01 disarms; a later edge must then do nothing
      wr(2, 16'h0002);
      `CHK("armed", 1'b0, hiz_start_armed)
      err(1'b1);
      `CHK("hiz_active", 1'b0, hiz_active)
      `CHK("oe", {AHZ_PWM_W{1'b1}}, pwm_oe)
      err(1'b0);
      $display("test disarm done");
      finish_test();
   end
endmodule : ahz_ctrl_tb
`default_nettype wire

/* File: ahz_edge_det.sv */
`timescale 1ns/10ps
`default_nettype none
module ahz_edge_det (
   input wire logic mclk,
   input wire logic srst,
   input wire logic req_in,
   ahz_edge_if.det edge_o
);
   import ahz_pkg::*;

   typedef struct packed {
      logic lvl; // Request level, one cycle late
      logic rise; // Edge pulse
   } ahz_det_st_t;

   ahz_det_st_t st_q;
   ahz_det_st_t st_d;

   ////////////////////////////////////////////////////////////////////////
   // Next state: a rise is a low-to-high step of the sampled request
   always_comb begin
      st_d = st_q;
      st_d.lvl = req_in;
      st_d.rise = req_in & ~st_q.lvl;
   end

   // Register; level preset high so a request already high at release is no edge
   always_ff @(posedge mclk) begin
      if (srst) begin
         st_q.lvl <= 1'b1; // Preset high: no false rise after release
         st_q.rise <= 1'b0; // No pulse pending
      end else begin
         st_q <= st_d;
      end
   end

   assign edge_o.rise = st_q.rise;
   assign edge_o.level = st_q.lvl;
endmodule : ahz_edge_det
`default_nettype wire

/* File: ahz_edge_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Carries the request edge and level from detector to latch
interface ahz_edge_if;
   logic rise; // One-cycle pulse on request rising edge
   logic level; // Registered request level
   modport det (output rise, output level);
   modport use_side (input rise, input level);
endinterface : ahz_edge_if
`default_nettype wire

/* File: ahz_far_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Stand-in for the interconnect and the motor timer
module ahz_far_model (
   input wire logic mclk,
   input wire logic srst,
   input wire logic timer_err, // Timer error interrupt level
   input wire logic [7:0] hiz_source_enable, // Interconnect source select
   output logic hiz_req, // Request toward the block
   output logic [ahz_pkg::AHZ_PWM_W-1:0] pwm_in // Timer drive levels
);
   import ahz_pkg::*;
   ////////////////////////////////////////////////////////////////////////
   // Only the timer error source (bit 3) is passed on as the request
   assign hiz_req = timer_err & hiz_source_enable[3];
   // Pattern steps every cycle so a stale or frozen sample shows up
   always_ff @(posedge mclk) begin
      if (srst) begin
         pwm_in <= '0;
      end else begin
         pwm_in <= pwm_in + AHZ_PWM_W'(1);
      end
   end
endmodule : ahz_far_model
`default_nettype wire

/* File: ahz_pkg.sv */
package ahz_pkg;
   // Mode configuration values written by software
   localparam logic [15:0] AHZ_MODE_FREE_REL = 16'h0004; // Release at any request level
   localparam logic [15:0] AHZ_MODE_QUAL_REL = 16'h0014; // Release only while request low
   localparam int AHZ_QUAL_BIT = 4; // Bit that selects level-qualified release
   localparam logic [7:0] AHZ_ENABLE_VAL = 8'h01; // Write enable / arm / stop value
   localparam logic [15:0] AHZ_MODE_RST = 16'h0000; // Mode after reset
   localparam int AHZ_PWM_W = 6; // Motor outputs (three phases, two legs)

   // Latch state
   typedef enum logic [0:0] {
      AHZ_DRIVE = 1'b0, // Normal PWM drive
      AHZ_HIZ = 1'b1 // Outputs released to high impedance
   } ahz_state_t;
endpackage : ahz_pkg
